// ===== hdl/linear_ccd_readout.sv
// Readout sequencing model of a 2880 pixel linear CCD sensor
`timescale 1ns/1ps
`default_nettype none

module linear_ccd_readout (
  // Clock and reset
  input  wire logic                          core_clk_i,
  input  wire logic                          nrst_i,
  // Sensor clock pins from the timing generator
  input  wire logic                          shift_gate_clock_i,
  input  wire logic                          transfer_phase1_i,
  input  wire logic                          transfer_phase2_i,
  input  wire logic                          output_reset_clock_i,
  // Exposure of the photosites
  input  wire logic                          exp_we_i,
  input  wire logic [ccd_readout_pkg::POS_W-1:0] exp_addr_i,
  input  wire logic [ccd_readout_pkg::PIX_W-1:0] exp_level_i,
  // Element stream towards the front end
  output logic                               pix_valid_o,
  output ccd_readout_pkg::pixel_word_s       pix_word_o,
  input  wire logic                          pix_ready_i,
  // Output stage levels
  output logic [ccd_readout_pkg::PIX_W-1:0]  signal_output_o,
  output logic [ccd_readout_pkg::PIX_W-1:0]  compensation_output_o,
  // Drive monitors
  output logic                               line_short_o,
  output logic                               overrun_o,
  output logic                               phase_overlap_o
);

  localparam int NPIN = 4;
  localparam int HW = ccd_readout_pkg::POS_W - 1;

  // Pin synchronisers, one per sensor clock
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] sync1;
  logic [NPIN-1:0] sync2;
  logic [NPIN-1:0] sync3;
  logic [NPIN-1:0] level;
  logic [NPIN-1:0] next_level;
  logic [NPIN-1:0] rise;

  assign pin_raw = {output_reset_clock_i, transfer_phase2_i,
                    transfer_phase1_i, shift_gate_clock_i};

  genvar g;
  generate
    for (g = 0; g < NPIN; g++) begin : g_sync
      // A level counts only once stages two and three agree
      always_comb begin
        next_level[g] = (sync2[g] == sync3[g]) ? sync3[g] : level[g];
      end
      always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
          sync1[g] <= 1'b0;
          sync2[g] <= 1'b0;
          sync3[g] <= 1'b0;
          level[g] <= 1'b0;
        end else begin
          sync1[g] <= pin_raw[g];
          sync2[g] <= sync1[g];
          sync3[g] <= sync2[g];
          level[g] <= next_level[g];
        end
      end
      assign rise[g] = next_level[g] && !level[g];
    end
  endgenerate

  logic sg_rise;
  logic p1_rise;
  logic clr_rise;
  assign sg_rise = rise[0];
  assign p1_rise = rise[1];
  assign clr_rise = rise[3];

  // Photosite charge, two banks per parity; one integrates, one reads
  logic [ccd_readout_pkg::PIX_W-1:0] odd_mem  [2][ccd_readout_pkg::HALF_CNT];
  logic [ccd_readout_pkg::PIX_W-1:0] even_mem [2][ccd_readout_pkg::HALF_CNT];
  logic bank;
  logic next_bank;

  // Exposure writes land in the integrating bank only
  always_ff @(posedge core_clk_i) begin
    if (exp_we_i && exp_addr_i < ccd_readout_pkg::POS_W'(
        ccd_readout_pkg::VALID_CNT)) begin
      if (!exp_addr_i[0]) begin
        odd_mem[~bank][exp_addr_i[HW:1]] <= exp_level_i;
      end else begin
        even_mem[~bank][exp_addr_i[HW:1]] <= exp_level_i;
      end
    end
  end

  // Readout sequencer state
  logic [ccd_readout_pkg::POS_W-1:0] pos;
  logic [ccd_readout_pkg::POS_W-1:0] next_pos;
  logic [ccd_readout_pkg::POS_W-1:0] p1_count;
  logic [ccd_readout_pkg::POS_W-1:0] next_p1_count;
  logic pending;
  logic next_pending;
  logic line_short;
  logic next_line_short;
  logic overrun;
  logic next_overrun;
  logic overlap;
  logic next_overlap;

  // Element that sits at the output stage now
  ccd_readout_pkg::pixel_word_s cur_word;
  logic [ccd_readout_pkg::POS_W-1:0] site;
  logic buf_ready;
  logic emit;

  assign site = pos - ccd_readout_pkg::VALID_START;

  // Classify the current line position
  always_comb begin
    cur_word.index = pos;
    cur_word.level = ccd_readout_pkg::BLANK_LEVEL;
    if (pos < ccd_readout_pkg::BLACK_START) begin
      cur_word.kind = ccd_readout_pkg::EL_BLANK;
    end else if (pos < ccd_readout_pkg::LEAD_START) begin
      cur_word.kind  = ccd_readout_pkg::EL_BLACK;
      cur_word.level = ccd_readout_pkg::DARK_LEVEL;
    end else if (pos < ccd_readout_pkg::VALID_START) begin
      cur_word.kind  = ccd_readout_pkg::EL_LEAD;
      cur_word.level = ccd_readout_pkg::DARK_LEVEL;
    end else if (pos < ccd_readout_pkg::TAIL_START) begin
      cur_word.kind  = ccd_readout_pkg::EL_VALID;
      cur_word.index = site;
      cur_word.level = site[0] ? even_mem[bank][site[HW:1]]
                               : odd_mem[bank][site[HW:1]];
    end else if (pos < ccd_readout_pkg::LINE_END) begin
      cur_word.kind  = ccd_readout_pkg::EL_TAIL;
      cur_word.level = ccd_readout_pkg::DARK_LEVEL;
    end else begin
      cur_word.kind = ccd_readout_pkg::EL_EMPTY;
    end
  end

  // A phase-one edge shifts one element; a full buffer defers it once
  assign emit = (p1_rise || pending) && buf_ready;

  // Sequencer next values
  always_comb begin
    next_bank       = bank;
    next_pos        = pos;
    next_pending    = pending;
    next_p1_count   = p1_count;
    next_line_short = line_short;
    next_overrun    = overrun;
    next_overlap    = overlap || (level[1] && level[2]);
    if (p1_rise && p1_count != '1) begin
      next_p1_count = p1_count + 1'b1;
    end
    if (p1_rise && !buf_ready) begin
      next_overrun = overrun || pending;
      next_pending = 1'b1;
    end else if (emit && !(p1_rise && pending)) begin
      // An edge on top of a pending step leaves one still owed
      next_pending = 1'b0;
    end
    if (emit && pos != ccd_readout_pkg::LINE_END) begin
      next_pos = pos + 1'b1;
    end
    if (sg_rise) begin
      // Frozen charge becomes the readout bank, line restarts
      next_bank       = ~bank;
      next_pos        = '0;
      next_pending    = 1'b0;
      next_p1_count   = '0;
      next_line_short =
        (p1_count <= ccd_readout_pkg::MIN_P1_COUNT);
    end
  end

  // Sequencer registers
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      bank       <= 1'b0;
      pos        <= ccd_readout_pkg::LINE_END;
      pending    <= 1'b0;
      p1_count   <= '0;
      line_short <= 1'b0;
      overrun    <= 1'b0;
      overlap    <= 1'b0;
    end else begin
      bank       <= next_bank;
      pos        <= next_pos;
      pending    <= next_pending;
      p1_count   <= next_p1_count;
      line_short <= next_line_short;
      overrun    <= next_overrun;
      overlap    <= next_overlap;
    end
  end

  assign line_short_o    = line_short;
  assign overrun_o       = overrun;
  assign phase_overlap_o = overlap;

  // Two entries absorb a reader stall without losing an element
  logic                                        out_valid;
  logic [$bits(ccd_readout_pkg::pixel_word_s)-1:0] out_data;

  pixel_skid_buffer #(
    .W     ($bits(ccd_readout_pkg::pixel_word_s)),
    .DEPTH (2)
  ) u_buffer (
    .core_clk_i  (core_clk_i),
    .nrst_i      (nrst_i),
    .in_valid_i  (emit),
    .in_data_i   (cur_word),
    .in_ready_o  (buf_ready),
    .out_valid_o (out_valid),
    .out_data_o  (out_data),
    .out_ready_i (pix_ready_i)
  );

  assign pix_valid_o = out_valid;
  assign pix_word_o  = ccd_readout_pkg::pixel_word_s'(out_data);

  // Output stage levels
  logic [ccd_readout_pkg::PIX_W-1:0] sig_level;
  logic [ccd_readout_pkg::PIX_W-1:0] next_sig_level;
  logic [ccd_readout_pkg::PIX_W-1:0] comp_level;
  ccd_readout_pkg::pixel_word_s      taken;

  assign taken = ccd_readout_pkg::pixel_word_s'(out_data);

  // Detector follows each taken element; reset clock clears it
  always_comb begin
    next_sig_level = sig_level;
    if (out_valid && pix_ready_i) begin
      next_sig_level = ccd_readout_pkg::DC_LEVEL + taken.level;
    end else if (clr_rise) begin
      next_sig_level = ccd_readout_pkg::DC_LEVEL;
    end
  end

  // Compensation side never sees charge, only the DC level
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sig_level  <= ccd_readout_pkg::DC_LEVEL;
      comp_level <= ccd_readout_pkg::DC_LEVEL;
    end else begin
      sig_level  <= next_sig_level;
      comp_level <= ccd_readout_pkg::DC_LEVEL;
    end
  end

  assign signal_output_o       = sig_level;
  assign compensation_output_o = comp_level;

endmodule

`default_nettype wire

// ===== common/ccd_readout_pkg.sv
// Shared constants and types for the linear CCD readout model
package ccd_readout_pkg;

  // Widths
  localparam int POS_W = 12;
  localparam int PIX_W = 12;
  localparam int SYNC_STAGES = 3;

  // Line layout, in output elements
  localparam int BLANK_CNT = 16;
  localparam int BLACK_CNT = 13;
  localparam int INVALID_CNT = 3;
  localparam int VALID_CNT = 2880;
  localparam int HALF_CNT = VALID_CNT / 2;
  localparam int MIN_P1_PERIODS = 1460;

  // Element boundaries along the line
  localparam logic [POS_W-1:0] BLACK_START = POS_W'(BLANK_CNT);
  localparam logic [POS_W-1:0] LEAD_START = POS_W'(BLANK_CNT + BLACK_CNT);
  localparam logic [POS_W-1:0] VALID_START =
    POS_W'(BLANK_CNT + BLACK_CNT + INVALID_CNT);
  localparam logic [POS_W-1:0] TAIL_START =
    POS_W'(BLANK_CNT + BLACK_CNT + INVALID_CNT + VALID_CNT);
  localparam logic [POS_W-1:0] LINE_END =
    POS_W'(BLANK_CNT + BLACK_CNT + 2 * INVALID_CNT + VALID_CNT);
  localparam logic [POS_W-1:0] MIN_P1_COUNT = POS_W'(MIN_P1_PERIODS);

  // Output levels and reset values
  localparam logic [PIX_W-1:0] DC_LEVEL = 12'h800;
  localparam logic [PIX_W-1:0] DARK_LEVEL = 12'h010;
  localparam logic [PIX_W-1:0] BLANK_LEVEL = 12'h000;

  // Kind of element on the output, Gray coded along the line
  typedef enum logic [2:0] {
    EL_BLANK = 3'h0,
    EL_BLACK = 3'h1,
    EL_LEAD  = 3'h3,
    EL_VALID = 3'h2,
    EL_TAIL  = 3'h6,
    EL_EMPTY = 3'h7
  } element_e;

  // One element as shifted out of the register
  typedef struct packed {
    element_e         kind;
    logic [POS_W-1:0] index;
    logic [PIX_W-1:0] level;
  } pixel_word_s;

endpackage

// ===== hdl/pixel_skid_buffer.sv
// Small valid/ready buffer between the shift register and the reader
`timescale 1ns/1ps
`default_nettype none

module pixel_skid_buffer #(
  parameter int W     = 8,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input  wire logic         core_clk_i,
  input  wire logic         nrst_i,
  // Filling side
  input  wire logic         in_valid_i,
  input  wire logic [W-1:0] in_data_i,
  output logic              in_ready_o,
  // Draining side
  output logic              out_valid_o,
  output logic [W-1:0]      out_data_o,
  input  wire logic         out_ready_i
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] FULL_CNT = (AW + 1)'(DEPTH);

  logic [W-1:0] store [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0]   count;
  logic [AW-1:0] next_wr_ptr;
  logic [AW-1:0] next_rd_ptr;
  logic [AW:0]   next_count;
  logic          push;
  logic          pop;
  logic          head_valid;
  logic          next_head_valid;
  logic [W-1:0]  head_data;
  logic [W-1:0]  next_head_data;

  // Handshakes; full refuses, so the source must hold its word
  assign in_ready_o  = (count != FULL_CNT);
  // Head kept in flops so the reader sees registered outputs
  assign out_valid_o = head_valid;
  assign out_data_o  = head_data;
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  // Pointer and fill level next values
  always_comb begin
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count  = count;
    if (push) begin
      next_wr_ptr = (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
    end
    if (pop) begin
      next_rd_ptr = (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
    // Next head; a word landing on the head slot bypasses storage
    next_head_valid = (next_count != '0);
    next_head_data  = store[next_rd_ptr];
    if (push && next_rd_ptr == wr_ptr) begin
      next_head_data = in_data_i;
    end
  end

  // Pointer and fill level registers
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
      head_valid <= 1'b0;
      head_data  <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
      head_valid <= next_head_valid;
      head_data  <= next_head_data;
    end
  end

  // Storage needs no reset, empty entries are never shown as valid
  always_ff @(posedge core_clk_i) begin
    if (push) begin
      store[wr_ptr] <= in_data_i;
    end
  end

endmodule

`default_nettype wire

// ===== verification/linear_ccd_readout_props.sv
// Port checker for the linear CCD readout block
`timescale 1ns/1ps
`default_nettype none
module linear_ccd_readout_props (
  // Clock and reset
  input wire logic                         core_clk_i,
  input wire logic                         nrst_i,
  // Watched ports
  input wire logic                         transfer_phase1_i,
  input wire logic                         output_reset_clock_i,
  input wire logic                         pix_valid_o,
  input wire ccd_readout_pkg::pixel_word_s pix_word_o,
  input wire logic                         pix_ready_i,
  input wire logic [11:0]                  signal_output_o,
  input wire logic [11:0]                  compensation_output_o,
  input wire logic                         overrun_o,
  input wire logic                         phase_overlap_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);
  // Fields of the word on offer
  logic [11:0]                 lvl;
  logic [11:0]                 idx;
  ccd_readout_pkg::element_e   kd;
  assign lvl = pix_word_o.level;
  assign idx = pix_word_o.index;
  assign kd  = pix_word_o.kind;
  // Phase-one pulse held long enough to pass the synchroniser
  sequence s_p1_held;
    $rose(transfer_phase1_i) ##1 transfer_phase1_i [*3];
  endsequence
  property p_comp_dc;
    compensation_output_o == ccd_readout_pkg::DC_LEVEL;
  endproperty
  a_comp_dc: assert property (p_comp_dc) else $error("comp moved");
  property p_out_level;
    pix_valid_o && pix_ready_i |=>
      signal_output_o == ccd_readout_pkg::DC_LEVEL + $past(lvl);
  endproperty
  a_out_level: assert property (p_out_level) else $error("bad output");
  property p_hold;
    pix_valid_o && !pix_ready_i |=> pix_valid_o && $stable(pix_word_o);
  endproperty
  a_hold: assert property (p_hold) else $error("word dropped");
  property p_blank;
    pix_valid_o && kd == ccd_readout_pkg::EL_BLANK |->
      lvl == ccd_readout_pkg::BLANK_LEVEL && idx < 12'h010;
  endproperty
  a_blank: assert property (p_blank) else $error("bad blank");
  property p_black;
    pix_valid_o && kd == ccd_readout_pkg::EL_BLACK |->
      lvl == ccd_readout_pkg::DARK_LEVEL && idx inside {[12'h010:12'h01C]};
  endproperty
  a_black: assert property (p_black) else $error("bad black");
  property p_valid_idx;
    pix_valid_o && kd == ccd_readout_pkg::EL_VALID |-> idx < 12'hB40;
  endproperty
  a_valid_idx: assert property (p_valid_idx) else $error("bad site");
  property p_step;
    s_p1_held |-> ##[0:4] pix_valid_o;
  endproperty
  a_step: assert property (p_step) else $error("no word");
  // Reset clock pulse held long enough to pass the synchroniser
  sequence s_clr_held;
    $rose(output_reset_clock_i) ##1 output_reset_clock_i [*2];
  endsequence
  // A taken word in the recognition cycle wins over the clear
  property p_clr_level;
    s_clr_held ##1 !(pix_valid_o && pix_ready_i) |=>
      signal_output_o == ccd_readout_pkg::DC_LEVEL;
  endproperty
  a_clr_level: assert property (p_clr_level) else $error("no clear");
  property p_ovr_sticky;
    overrun_o |=> overrun_o;
  endproperty
  a_ovr_sticky: assert property (p_ovr_sticky) else $error("ovr fell");
  property p_ovl_sticky;
    phase_overlap_o |=> phase_overlap_o;
  endproperty
  a_ovl_sticky: assert property (p_ovl_sticky) else $error("ovl fell");
endmodule
bind linear_ccd_readout linear_ccd_readout_props u_props (
  .core_clk_i(core_clk_i), .nrst_i(nrst_i),
  .transfer_phase1_i(transfer_phase1_i), .pix_valid_o(pix_valid_o),
  .pix_word_o(pix_word_o), .pix_ready_i(pix_ready_i),
  .signal_output_o(signal_output_o),
  .compensation_output_o(compensation_output_o),
  .output_reset_clock_i(output_reset_clock_i),
  .overrun_o(overrun_o), .phase_overlap_o(phase_overlap_o));
`default_nettype wire

// ===== verification/ccd_timing_gen.sv
// Timing generator model driving the sensor clock pins
`timescale 1ns/1ps
`default_nettype none
module ccd_timing_gen (
  // Clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        nrst_i,
  // Line request
  input  wire logic        go_i,
  input  wire logic [12:0] pulses_i,
  input  wire logic        overlap_i,
  // Sensor pins
  output logic             sg_o,
  output logic             p1_o,
  output logic             p2_o,
  output logic             rclk_o,
  output logic             busy_o
);
  logic [12:0] n;
  logic [2:0]  ph;
  logic [3:0]  sgc;
  logic        run;
  // Shift gate first, then eight-clock pixel periods
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      n <= '0;
      ph <= '0;
      sgc <= '0;
    end else if (go_i) begin
      sgc <= 4'h8;
      n <= pulses_i;
      ph <= '0;
    end else if (sgc != 4'h0) begin
      sgc <= sgc - 4'h1;
    end else if (n != 13'h0) begin
      ph <= ph + 3'h1;
      if (ph == 3'h7) begin
        n <= n - 13'h1;
      end
    end
  end
  // Phases never overlap unless a test asks for it
  assign run    = sgc == 4'h0 && n != 13'h0;
  assign sg_o   = sgc > 4'h4;
  assign p1_o   = run && !ph[2];
  assign p2_o   = run && (ph[2] || overlap_i);
  assign rclk_o = run && ph[2] && ph != 3'h7;
  assign busy_o = sgc != 4'h0 || n != 13'h0;
endmodule
`default_nettype wire

// ===== verification/linear_ccd_readout_bench.sv
// Self-checking bench for the linear CCD readout block
`timescale 1ns/1ps
`default_nettype none
`define CHECK(nm, e, a) begin compares++; if ((a) !== (e)) begin \
  num_errors++; $display("MISMATCH %s exp %h got %h", nm, e, a); end end
module linear_ccd_readout_bench;
  logic                        clk, nrst, we, ready, go, ovl, hold, stall;
  logic                        sg, p1, p2, rclk, busy, pv, lshort, ovr, ovp;
  logic                        take;
  logic [11:0]                 addr, lvl, so, co;
  logic [12:0]                 npls;
  ccd_readout_pkg::pixel_word_s pw, ew;
  int                          num_errors, compares, exp_pos, cyc;
  logic                        chk_en;
  ccd_timing_gen gen (.core_clk_i(clk), .nrst_i(nrst), .go_i(go),
    .pulses_i(npls), .overlap_i(ovl), .sg_o(sg), .p1_o(p1), .p2_o(p2),
    .rclk_o(rclk), .busy_o(busy));
  linear_ccd_readout dut (.core_clk_i(clk), .nrst_i(nrst),
    .shift_gate_clock_i(sg), .transfer_phase1_i(p1),
    .transfer_phase2_i(p2), .output_reset_clock_i(rclk), .exp_we_i(we),
    .exp_addr_i(addr), .exp_level_i(lvl), .pix_valid_o(pv),
    .pix_word_o(pw), .pix_ready_i(ready), .signal_output_o(so),
    .compensation_output_o(co), .line_short_o(lshort), .overrun_o(ovr),
    .phase_overlap_o(ovp));
  // Distinct charge per site exposes odd/even bank mixups
  function automatic logic [11:0] lvl_of(int i);
    return 12'(i) ^ 12'h5A5;
  endfunction
  // Expected element at a line position
  function automatic ccd_readout_pkg::pixel_word_s exp_word(int p);
    exp_word.index = 12'(p);
    exp_word.level = ccd_readout_pkg::DARK_LEVEL;
    exp_word.kind  = ccd_readout_pkg::EL_EMPTY;
    if (p < 16) begin
      exp_word.kind  = ccd_readout_pkg::EL_BLANK;
      exp_word.level = ccd_readout_pkg::BLANK_LEVEL;
    end else if (p < 29) exp_word.kind = ccd_readout_pkg::EL_BLACK;
    else if (p < 32) exp_word.kind = ccd_readout_pkg::EL_LEAD;
    else if (p < 2912) begin
      exp_word.kind  = ccd_readout_pkg::EL_VALID;
      exp_word.index = 12'(p - 32);
      exp_word.level = lvl_of(p - 32);
    end else if (p < 2915) exp_word.kind = ccd_readout_pkg::EL_TAIL;
  endfunction
  // Clock; the stall pattern below is one the buffer must absorb
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Cycle count for the run limit
  always @(posedge clk) cyc++;
  // Ready for the next edge; the word it takes is judged while settled
  always @(negedge clk) begin
    take = !hold && !(stall && cyc[4:3] == 2'h3);
    ready <= take;
    if (chk_en && pv && take) begin
      ew = exp_word(exp_pos);
      `CHECK("kind", ew.kind, pw.kind)
      if (ew.kind !== ccd_readout_pkg::EL_EMPTY) begin
        `CHECK("index", ew.index, pw.index)
        `CHECK("level", ew.level, pw.level)
      end
      exp_pos++;
    end
    if (cyc > 80000) begin
      num_errors++;
      conclude();
    end
  end
  task automatic run_line(input int n);
    exp_pos = 0;
    @(negedge clk);
    npls = 13'(n);
    go = 1'b1;
    @(negedge clk);
    go = 1'b0;
    while (busy) @(negedge clk);
    repeat (16) @(negedge clk);
  endtask
  task automatic t_short;
    chk_en = 1'b1;
    run_line(5);
    `CHECK("words", 5, exp_pos)
    $display("short line done");
  endtask
  // Charge for every photosite into the integrating bank
  task automatic expose;
    for (int i = 0; i < 2880; i++) begin
      @(negedge clk);
      we = 1'b1;
      addr = 12'(i);
      lvl = lvl_of(i);
    end
    @(negedge clk);
    we = 1'b0;
  endtask
  task automatic t_full;
    expose();
    stall = 1'b1;
    run_line(2920);
    `CHECK("short", 1'b1, lshort)
    `CHECK("words", 2920, exp_pos)
    // Fill the other bank too, later lines read it
    expose();
    run_line(0);
    `CHECK("short", 1'b0, lshort)
    stall = 1'b0;
    $display("full line done");
  endtask
  task automatic t_faults;
    chk_en = 1'b0;
    hold = 1'b1;
    run_line(3);
    `CHECK("overrun", 1'b0, ovr)
    run_line(2);
    `CHECK("overrun", 1'b1, ovr)
    hold = 1'b0;
    ovl = 1'b1;
    run_line(1);
    ovl = 1'b0;
    `CHECK("overlap", 1'b1, ovp)
    // Both sides of the line length limit
    run_line(1460);
    run_line(1461);
    `CHECK("short", 1'b1, lshort)
    run_line(0);
    `CHECK("short", 1'b0, lshort)
    nrst = 1'b0;
    repeat (4) @(negedge clk);
    `CHECK("flags", 3'h0, {pv, ovr, ovp})
    `CHECK("dc", ccd_readout_pkg::DC_LEVEL, so)
    nrst = 1'b1;
    $display("fault test done");
  endtask
  task automatic conclude;
    $display("compares %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    {nrst, we, go, ovl, hold, stall, chk_en} = '0;
    {addr, lvl, npls} = '0;
    repeat (20) @(negedge clk);
    nrst = 1'b1;
    t_short();
    t_full();
    t_faults();
    conclude();
  end
endmodule
`default_nettype wire
